//--- core/irac_regs.vh
// register offsets, field positions and timing constants for remote access control
`ifndef IRAC_REGS_VH
`define IRAC_REGS_VH
`define IRAC_OFS_CTRL        8'h05
`define IRAC_OFS_BRIDGE      8'h06
`define IRAC_OFS_TGT0        8'h07
`define IRAC_OFS_ALIAS0      8'h08
`define IRAC_CTRL_MASK       8'h1f
`define IRAC_ADDR_MASK       8'hfe
`define IRAC_CTRL_RESET      8'h00
`define IRAC_BRIDGE_RESET    8'h00
`define IRAC_BIT_WD_DIS      0
`define IRAC_BIT_WD_FAST     1
`define IRAC_BIT_LWR_DIS     2
`define IRAC_SDA_DLY_LSB     3
`define IRAC_BIT_FREEZE      0
`define IRAC_CLK_NS          20
`define IRAC_SDA_BASE_NS     240
`define IRAC_SDA_STEP_NS     40
`define IRAC_WD_SLOW_US      1000000
`define IRAC_WD_FAST_US      50
`define IRAC_RECOVER_PULSES  9
`define IRAC_SCL_HALF_NS     5000
`endif

//--- core/irac_delay_line.v
// programmable delay of the sda output relative to scl
`timescale 1ns/100ps
`default_nettype none
`include "irac_regs.vh"
module irac_delay_line #(
    parameter DEPTH = 18
) (
    input  wire       i_clock,
    input  wire       i_srst,
    input  wire [1:0] i_sel,
    input  wire       i_d,
    output wire       o_q
);
    // ========================================
    // shift line, tap picked by setting
    localparam BASE = (`IRAC_SDA_BASE_NS + `IRAC_CLK_NS - 1) / `IRAC_CLK_NS;
    localparam STEP = `IRAC_SDA_STEP_NS / `IRAC_CLK_NS;
    reg [DEPTH-1:0] line_r;
    // line idles high so the bus is released out of reset
    always @(posedge i_clock) begin
        if (i_srst)
            line_r <= {DEPTH{1'b1}};
        else
            line_r <= {line_r[DEPTH-2:0], i_d};
    end
    assign o_q = line_r[BASE - 1 + STEP * i_sel];
endmodule // irac_delay_line
`default_nettype wire

//--- core/irac_ctrl.v
// remote access control: registers, address remap, write guard and bus watchdog
`timescale 1ns/100ps
`default_nettype none
`include "irac_regs.vh"
module irac_ctrl #(
    parameter WD_SLOW_CYCLES = `IRAC_WD_SLOW_US * 1000 / `IRAC_CLK_NS,
    parameter HALF_CYCLES    = `IRAC_SCL_HALF_NS / `IRAC_CLK_NS
) (
    input  wire       i_clock,
    input  wire       i_srst,
    input  wire       i_reg_we,
    input  wire       i_reg_remote,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    output wire       o_reg_write_refused,
    input  wire       i_second_port_select,
    input  wire       i_link_lock,
    input  wire [6:0] i_link_bridge_addr,
    input  wire       i_tx_valid,
    input  wire [6:0] i_tx_addr,
    output wire       o_tx_forward,
    output wire [6:0] o_tx_addr,
    input  wire       i_scl,
    input  wire       i_sda,
    input  wire       i_sda_drive,
    output wire       o_sda_oe,
    output wire       o_sda_out,
    output reg        o_scl_oe,
    output wire       o_scl_out,
    output reg        o_bus_free,
    output wire       o_recovering
);
    // ========================================
    // timing
    localparam [31:0] WD_FAST_CYCLES = `IRAC_WD_FAST_US * 1000 / `IRAC_CLK_NS;
    localparam [1:0] ST_WATCH = 2'd0, ST_LOW = 2'd1, ST_HIGH = 2'd2;
    // control reset narrowed on purpose, bits 7:5 are never stored
    localparam [7:0] CTRL_RST = `IRAC_CTRL_RESET;

    // ========================================
    // address registers, one set per port; control register shared by both
    reg [4:0] ctrl_r;
    reg [7:0] bridge_r [0:1];
    reg [7:0] tgt_r    [0:1];
    reg [7:0] alias_r  [0:1];
    wire      psel = i_second_port_select;

    function [6:0] addr_field;
        input [7:0] v;
        addr_field = v[7:1];
    endfunction

    // only local writes pass once the guard is up
    wire wr_ok = i_reg_we && !(i_reg_remote && ctrl_r[`IRAC_BIT_LWR_DIS]);
    assign o_reg_write_refused = i_reg_we && !wr_ok;

    // ignoring writes keeps reserved bits at zero
    integer p;
    always @(posedge i_clock) begin
        if (i_srst) begin
            ctrl_r <= CTRL_RST[4:0];
            for (p = 0; p < 2; p = p + 1) begin
                bridge_r[p] <= `IRAC_BRIDGE_RESET;
                tgt_r[p]    <= `IRAC_BRIDGE_RESET;
                alias_r[p]  <= `IRAC_BRIDGE_RESET;
            end
        end else begin
            // link load first, so a software write in the same cycle wins
            if (i_link_lock && !bridge_r[psel][`IRAC_BIT_FREEZE])
                bridge_r[psel] <= {i_link_bridge_addr, 1'b0};
            if (wr_ok) begin
                case (i_reg_addr)
                    `IRAC_OFS_CTRL:   ctrl_r <= i_reg_wdata[4:0];
                    `IRAC_OFS_BRIDGE: bridge_r[psel] <= i_reg_wdata;
                    `IRAC_OFS_TGT0:   tgt_r[psel] <= i_reg_wdata & `IRAC_ADDR_MASK;
                    `IRAC_OFS_ALIAS0: alias_r[psel] <= i_reg_wdata & `IRAC_ADDR_MASK;
                    default: ;
                endcase
            end
        end
    end

    // read mux, unmapped reads return zero
    always @* begin
        case (i_reg_addr)
            `IRAC_OFS_CTRL:   o_reg_rdata = {3'b000, ctrl_r};
            `IRAC_OFS_BRIDGE: o_reg_rdata = bridge_r[psel];
            `IRAC_OFS_TGT0:   o_reg_rdata = tgt_r[psel];
            `IRAC_OFS_ALIAS0: o_reg_rdata = alias_r[psel];
            default:          o_reg_rdata = 8'h00;
        endcase
    end

    // ========================================
    // address remap toward the far side
    // notes on the remap path:
    //   - the compare is purely combinational, so a transaction address
    //     presented with valid is answered in the same cycle
    //   - an alias hit takes priority over a bridge address hit; software
    //     should not program the alias equal to the bridge address
    //   - a zero alias or a zero target address keeps the alias path shut,
    //     so a half-programmed pair never forwards to address zero
    //   - a zero bridge address shuts off access to the remote bridge
    //   - the port select picks which copy of the fields is compared; a
    //     transaction for the other port is not seen until it is selected
    wire [6:0] bridge_a = addr_field(bridge_r[psel]);
    wire [6:0] tgt_a    = addr_field(tgt_r[psel]);
    wire [6:0] alias_a  = addr_field(alias_r[psel]);
    wire alias_hit   = (alias_a != 7'h00) && (tgt_a != 7'h00) && (i_tx_addr == alias_a);
    wire bridge_hit  = (bridge_a != 7'h00) && (i_tx_addr == bridge_a);
    // the write guard does not appear here: bus target access is unaffected
    assign o_tx_forward = i_tx_valid && (alias_hit || bridge_hit);
    assign o_tx_addr    = alias_hit ? tgt_a : i_tx_addr;

    // ========================================
    // sda output delay
    irac_delay_line u_dly (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_sel   (ctrl_r[`IRAC_SDA_DLY_LSB+1:`IRAC_SDA_DLY_LSB]),
        .i_d     (~i_sda_drive),
        .o_q     (o_sda_out)
    );
    assign o_sda_oe = ~o_sda_out;

    // ========================================
    // bus watchdog
    // notes on the watchdog:
    //   - any change on either bus line restarts the idle count, so a slow
    //     but live transfer never trips it
    //   - the limit is read every cycle; flipping the speedup bit mid-count
    //     can end the current interval at once
    //   - a free bus is only reported, nothing is driven
    //   - a stuck-low sda gets nine low/high scl periods, low half first,
    //     then the block returns to watching; if sda is still low the whole
    //     sequence repeats after another interval
    //   - recovery pulses are not stopped by the disable bit once started,
    //     which keeps scl from being left parked low
    //   - counters are wide enough for the slow interval at this clock
    reg [1:0]  st_r;
    reg [31:0] idle_r;
    reg [31:0] half_r;
    reg [4:0]  edge_r;
    reg        scl_q_r;
    reg        sda_q_r;
    wire activity = (i_scl != scl_q_r) || (i_sda != sda_q_r);
    wire [31:0] limit = ctrl_r[`IRAC_BIT_WD_FAST] ? WD_FAST_CYCLES : WD_SLOW_CYCLES;
    wire timeout = (idle_r >= limit - 32'd1);
    assign o_recovering = (st_r != ST_WATCH);
    assign o_scl_out    = 1'b0;

    // idle count, then recovery pulses on scl
    always @(posedge i_clock) begin
        if (i_srst) begin
            st_r <= ST_WATCH;
            idle_r <= 32'h0;
            half_r <= 32'h0;
            edge_r <= 5'h00;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            o_scl_oe <= 1'b0;
            o_bus_free <= 1'b0;
        end else begin
            scl_q_r <= i_scl;
            sda_q_r <= i_sda;
            case (st_r)
                ST_WATCH: begin
                    o_scl_oe <= 1'b0;
                    if (ctrl_r[`IRAC_BIT_WD_DIS] || activity) begin
                        idle_r <= 32'h0;
                        o_bus_free <= 1'b0;
                    end else if (timeout) begin
                        idle_r <= 32'h0;
                        if (i_sda) begin
                            o_bus_free <= 1'b1;
                        end else begin
                            st_r <= ST_LOW;
                            o_scl_oe <= 1'b1;
                            half_r <= 32'h0;
                            edge_r <= 5'h00;
                        end
                    end else
                        idle_r <= idle_r + 32'd1;
                end
                ST_LOW, ST_HIGH: begin
                    if (half_r >= HALF_CYCLES - 1) begin
                        half_r <= 32'h0;
                        edge_r <= edge_r + 5'd1;
                        if (edge_r == 2 * `IRAC_RECOVER_PULSES - 1) begin
                            st_r <= ST_WATCH;
                            o_scl_oe <= 1'b0;
                        end else begin
                            st_r <= (st_r == ST_LOW) ? ST_HIGH : ST_LOW;
                            o_scl_oe <= (st_r == ST_HIGH);
                        end
                    end else
                        half_r <= half_r + 32'd1;
                end
                default: st_r <= ST_WATCH;
            endcase
        end
    end
endmodule // irac_ctrl
`default_nettype wire

//--- test/irac_bus_model.sv
// local bus wires with pull-ups, shared by the device and a far-side master
`timescale 1ns/100ps
`default_nettype none
module irac_bus_model (
    input  wire logic i_sda_oe,
    input  wire logic i_scl_oe,
    input  wire logic i_hold_sda,
    input  wire logic i_pulse_scl,
    output wire logic o_sda,
    output wire logic o_scl
);
    // released lines float high, so any party pulling low wins
    assign o_sda = !(i_sda_oe || i_hold_sda);
    assign o_scl = !(i_scl_oe || i_pulse_scl);
endmodule // irac_bus_model
`default_nettype wire

//--- test/irac_ctrl_assertions.sv
// port checker for remote access control
`timescale 1ns/100ps
`default_nettype none
module irac_ctrl_assertions (
    input wire logic       i_clock,
    input wire logic       i_srst,
    input wire logic       i_reg_we,
    input wire logic       i_reg_remote,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_reg_write_refused,
    input wire logic       i_sda,
    input wire logic       o_sda_oe,
    input wire logic       o_sda_out,
    input wire logic       o_scl_oe,
    input wire logic       o_bus_free,
    input wire logic       o_recovering
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // released half of a recovery clock, fixed at four cycles in this bench
    sequence s_high_half; !o_scl_oe [*4]; endsequence
    a_sda_polarity: assert property (o_sda_oe != o_sda_out) else $error("sda oe");
    a_refuse_cause: assert property (o_reg_write_refused |-> i_reg_we && i_reg_remote)
        else $error("refused");
    a_refuse_when: assert property (i_reg_we && i_reg_remote && i_reg_addr == 8'h05
        && o_reg_rdata[2] |-> o_reg_write_refused) else $error("not refused");
    a_ctrl_reserved: assert property (i_reg_addr == 8'h05 |-> o_reg_rdata[7:5] == 3'h0)
        else $error("ctrl reserved");
    a_addr_bit0: assert property (i_reg_addr inside {8'h07, 8'h08} |-> !o_reg_rdata[0])
        else $error("bit0");
    a_free_sda_high: assert property ($rose(o_bus_free) |-> $past(i_sda)) else $error("free");
    a_scl_in_recovery: assert property (o_scl_oe |-> o_recovering) else $error("scl");
    a_scl_high_half: assert property ($fell(o_scl_oe) |-> s_high_half) else $error("half");
endmodule // irac_ctrl_assertions
bind irac_ctrl irac_ctrl_assertions u_irac_ctrl_assertions (.*);
`default_nettype wire

//--- test/tb.sv
// bench for remote access control
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb;
    logic       i_clock = 0, i_srst = 1, i_reg_we = 0, i_reg_remote = 0, i_link_lock = 0;
    logic       i_second_port_select = 0, i_tx_valid = 0, i_sda_drive = 0, hold = 0, pul = 0;
    logic       o_reg_write_refused, o_tx_forward, i_sda, i_scl, o_sda_oe, o_sda_out;
    logic       o_scl_oe, o_bus_free, o_recovering;
    logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
    logic [6:0] i_link_bridge_addr = 0, i_tx_addr = 0, o_tx_addr;
    int         miscompares = 0, checks = 0, n, rises = 0;
    initial forever #10 i_clock = ~i_clock;
    always @(posedge o_scl_oe) rises++;
    // short watchdog and half period keep the run brief
    irac_ctrl #(.WD_SLOW_CYCLES(200), .HALF_CYCLES(4)) u_irac_ctrl (.*, .o_scl_out());
    irac_bus_model u_irac_bus_model (.i_sda_oe(o_sda_oe), .i_scl_oe(o_scl_oe),
        .i_hold_sda(hold), .i_pulse_scl(pul), .o_sda(i_sda), .o_scl(i_scl));
    // one-cycle write, refusal flag sampled while the strobe is up
    task automatic wr(input logic [7:0] a, d, input logic r, x);
        @(negedge i_clock);
        {i_reg_addr, i_reg_wdata, i_reg_remote, i_reg_we} = {a, d, r, 1'b1};
        #1 `CHK("refused", x, o_reg_write_refused)
        @(negedge i_clock);
        i_reg_we = 0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge i_clock);
        i_reg_addr = a;
        #1 `CHK("rdata", e, o_reg_rdata)
    endtask
    task automatic idle(input int c);
        repeat (c) @(negedge i_clock);
    endtask
    task automatic final_report;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200us miscompares++;
        final_report();
    end
    initial begin
        idle(10);
        i_srst = 0;
        for (int a = 5; a < 10; a++) rd(a[7:0], 8'h00);
        wr(8'h05, 8'hff, 0, 0);
        wr(8'h05, 8'h00, 1, 1);
        rd(8'h05, 8'h1f);
        wr(8'h05, 8'h01, 0, 0);
        wr(8'h07, 8'ha0, 1, 0);
        wr(8'h08, 8'h75, 0, 0);
        i_tx_valid = 1;
        i_tx_addr = 7'h3a;
        rd(8'h08, 8'h74);
        `CHK("remap", 7'h50, o_tx_forward ? o_tx_addr : 7'h00)
        wr(8'h07, 8'h00, 0, 0);
        `CHK("forward", 1'b0, o_tx_forward)
        i_link_lock = 1;
        i_link_bridge_addr = 7'h2c;
        rd(8'h06, 8'h58);
        wr(8'h06, 8'h23, 0, 0);
        i_link_bridge_addr = 7'h33;
        i_second_port_select = 1;
        rd(8'h06, 8'h66);
        i_second_port_select = 0;
        rd(8'h06, 8'h23);
        for (int s = 0; s < 4; s++) begin
            wr(8'h05, {3'h0, s[1:0], 3'h1}, 0, 0);
            i_sda_drive = 1;
            for (n = 0; o_sda_out && n < 40; n++) #20;
            `CHK("sda delay", 12 + 2 * s, n)
            i_sda_drive = 0;
            idle(20);
        end
        idle(300);
        `CHK("free", 1'b0, o_bus_free)
        wr(8'h05, 8'h00, 0, 0);
        pul = 1;
        idle(1);
        pul = 0;
        idle(150);
        `CHK("free", 1'b0, o_bus_free)
        idle(100);
        `CHK("free", 1'b1, o_bus_free)
        hold = 1;
        idle(230);
        `CHK("recovering", 1'b1, o_recovering)
        `CHK("free", 1'b0, o_bus_free)
        idle(70);
        `CHK("recovering", 1'b0, o_recovering)
        `CHK("pulses", 9, rises)
        hold = 0;
        wr(8'h05, 8'h02, 0, 0);
        idle(300);
        `CHK("free", 1'b0, o_bus_free)
        idle(2300);
        `CHK("free", 1'b1, o_bus_free)
        final_report();
    end
endmodule // tb
`default_nettype wire
